// File: rtl/sdcs_pkg.sv
package sdcs_pkg;
	localparam int CLK_MHZ = 20;
	localparam int CLK_PERIOD_NS = 50;
	// Power-up pause in microseconds and its cycle count (least time, rounded up).
	localparam int POWERUP_US = 100;
	localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
	// Last write data to manual precharge, in nanoseconds.
	localparam int WRITE_RECOVERY_NS = 15;
	localparam int WRITE_RECOVERY_CYC_RAW = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// One whole clock must lie inside the recovery interval, so at least two edges pass.
	localparam int WRITE_RECOVERY_CYC = (WRITE_RECOVERY_CYC_RAW < 1) ? 2 : WRITE_RECOVERY_CYC_RAW + 1;
	// Interval defaults in cycles; the memory's own figures are not given here.
	localparam int REFRESH_CYCLE_CYC = 4;
	localparam int MODE_LOAD_CYC = 2;
	localparam int ROW_ACTIVE_CYC = 3;
	localparam int PRECHARGE_CYC = 2;
	localparam int REFRESH_PERIOD_CYC = 156;
	localparam int CNT_W = 16;
	localparam int WAKE_REFRESHES = 2;

	// Command encodings on cs_n, ras_n, cas_n, we_n.
	localparam logic [3:0] CMD_INHIBIT = 4'h8;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_ACTIVE = 4'h3;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_MODE = 4'h0;
	localparam int AP_BIT = 10;

	typedef struct packed {
		logic [3:0]  cmd;
		logic        cke;
		logic [1:0]  bank;
		logic [12:0] addr;
	} sdcs_bus_t;

	typedef struct packed {
		logic [1:0]  bank;
		logic [12:0] row;
		logic [9:0]  col;
		logic        auto_pre;
	} sdcs_req_t;
endpackage

// File: rtl/sdcs_timer.sv
`timescale 1ns/1ps
module sdcs_timer
	import sdcs_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             srst,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] value,
	output logic                  done
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		if (load) begin
			cnt_nxt = value;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign done = (cnt_r == '0) && !load;
endmodule // sdcs_timer

// File: rtl/sdcs_ctrl.sv
// Summary of operation
// R1 - Wait 100 us, then two refreshes.
// R2 - Redo two refreshes when refresh period overrun.
// R3 - Change clock only when stopped or powered down.
// R4 - Auto-precharge write keeps a full recovery clock.
// R5 - Only idle commands during refresh cycle interval.
// R6 - Idle command within mode-load delay after mode load.
// R7 - 15 ns from last write data to precharge.
// R8 - Open page write waits recovery before precharge.
// R9 - One refresh per refresh command issued.
// R10 - Keep refreshing while in power-down.
// R11 - Precharge only after row active minimum.
// R12 - Idle cycles drive NOP or inhibit.
`timescale 1ns/1ps
module sdcs_ctrl
	import sdcs_pkg::*;
#(
	parameter int POWERUP_CYCLES = POWERUP_CYC
)
(
	input  wire logic      mclk,
	input  wire logic      srst,
	input  wire logic      wr_valid,
	input  wire sdcs_req_t wr_req,
	output logic           wr_ready,
	input  wire logic      pd_req,
	input  wire logic      clk_change_req,
	output logic           clk_change_ok,
	output logic           init_done,
	output sdcs_bus_t      mem
);
	typedef enum logic [3:0] {
		SDCS_POWERUP = 4'h0,
		SDCS_WAKE_REF = 4'h1,
		SDCS_WAKE_WAIT = 4'h2,
		SDCS_MODE = 4'h3,
		SDCS_MODE_WAIT = 4'h4,
		SDCS_IDLE = 4'h5,
		SDCS_ACT_WAIT = 4'h6,
		SDCS_WR_WAIT = 4'h7,
		SDCS_PRE_WAIT = 4'h8,
		SDCS_REF_WAIT = 4'h9,
		SDCS_PDOWN = 4'ha,
		SDCS_WRITE = 4'hb,
		SDCS_PRE = 4'hc
	} sdcs_state_t;

	sdcs_state_t      st_r;
	sdcs_state_t      st_nxt;
	sdcs_bus_t        mem_r;
	sdcs_bus_t        mem_nxt;
	sdcs_req_t        req_r;
	sdcs_req_t        req_nxt;
	logic [1:0]       wake_r;
	logic [1:0]       wake_nxt;
	logic [CNT_W-1:0] refage_r;
	logic [CNT_W-1:0] refage_nxt;
	logic             init_r;
	logic             init_nxt;
	logic             tload;
	logic [CNT_W-1:0] tval;
	logic             tdone;
	logic             ras_load;
	logic             ras_done;
	logic [31:0]      pu_r;
	logic [31:0]      pu_nxt;

	sdcs_timer u_wait (
		.mclk  (mclk),
		.srst  (srst),
		.load  (tload),
		.value (tval),
		.done  (tdone)
	);

	// Row active minimum runs from ACTIVE independently of the recovery wait.
	sdcs_timer u_ras (
		.mclk  (mclk),
		.srst  (srst),
		.load  (ras_load),
		.value (CNT_W'(ROW_ACTIVE_CYC - 1)),
		.done  (ras_done)
	);

	function automatic sdcs_bus_t idle_cmd(input logic cke);
		sdcs_bus_t b;
		b = '0;
		b.cmd = CMD_NOP;
		b.cke = cke;
		return b;
	endfunction

	logic ref_due;
	assign ref_due = refage_r >= CNT_W'(REFRESH_PERIOD_CYC - REFRESH_CYCLE_CYC - 8);

	always_comb begin
		st_nxt = st_r;
		mem_nxt = idle_cmd(1'b1); // R12
		req_nxt = req_r;
		wake_nxt = wake_r;
		init_nxt = init_r;
		pu_nxt = pu_r;
		tload = 1'b0;
		tval = '0;
		ras_load = 1'b0;
		refage_nxt = (refage_r == '1) ? refage_r : refage_r + 16'h0001;
		case (st_r)
			SDCS_POWERUP: begin
				mem_nxt = idle_cmd(1'b1); // R12
				if (pu_r >= 32'(POWERUP_CYCLES - 1)) begin // R1
					st_nxt = SDCS_WAKE_REF;
					wake_nxt = 2'(WAKE_REFRESHES);
				end else begin
					pu_nxt = pu_r + 32'h00000001;
				end
			end
			SDCS_WAKE_REF: begin
				mem_nxt.cmd = CMD_REFRESH; // R9
				wake_nxt = wake_r - 2'h1;
				refage_nxt = '0;
				tload = 1'b1;
				tval = CNT_W'(REFRESH_CYCLE_CYC - 1);
				st_nxt = SDCS_WAKE_WAIT;
			end
			SDCS_WAKE_WAIT: begin
				if (tdone) begin // R5
					if (wake_r != 2'h0) begin
						st_nxt = SDCS_WAKE_REF; // R1
					end else if (init_r) begin
						st_nxt = SDCS_IDLE;
					end else begin
						st_nxt = SDCS_MODE;
					end
				end
			end
			SDCS_MODE: begin
				mem_nxt.cmd = CMD_MODE;
				mem_nxt.addr = 13'h0020;
				tload = 1'b1;
				tval = CNT_W'(MODE_LOAD_CYC - 1);
				st_nxt = SDCS_MODE_WAIT;
			end
			SDCS_MODE_WAIT: begin
				if (tdone) begin // R6
					init_nxt = 1'b1;
					st_nxt = SDCS_IDLE;
				end
			end
			SDCS_IDLE: begin
				if (refage_r >= CNT_W'(REFRESH_PERIOD_CYC)) begin // R2
					wake_nxt = 2'(WAKE_REFRESHES);
					st_nxt = SDCS_WAKE_REF;
				end else if (ref_due) begin
					mem_nxt.cmd = CMD_REFRESH; // R9
					refage_nxt = '0;
					tload = 1'b1;
					tval = CNT_W'(REFRESH_CYCLE_CYC - 1);
					st_nxt = SDCS_REF_WAIT;
				end else if (pd_req) begin
					mem_nxt.cke = 1'b0;
					st_nxt = SDCS_PDOWN;
				end else if (wr_valid) begin
					req_nxt = wr_req;
					mem_nxt.cmd = CMD_ACTIVE;
					mem_nxt.bank = wr_req.bank;
					mem_nxt.addr = wr_req.row;
					ras_load = 1'b1;
					tload = 1'b1;
					tval = CNT_W'(1);
					st_nxt = SDCS_ACT_WAIT;
				end
			end
			SDCS_ACT_WAIT: begin
				if (tdone) begin
					st_nxt = SDCS_WRITE;
				end
			end
			SDCS_WRITE: begin
				mem_nxt.cmd = CMD_WRITE;
				mem_nxt.bank = req_r.bank;
				mem_nxt.addr = {3'h0, req_r.col};
				mem_nxt.addr[AP_BIT] = req_r.auto_pre;
				tload = 1'b1;
				// Auto precharge needs the recovery clocks plus the precharge period.
				tval = req_r.auto_pre ? CNT_W'(WRITE_RECOVERY_CYC + PRECHARGE_CYC - 1) // R4
					: CNT_W'(WRITE_RECOVERY_CYC - 1); // R7 R8
				st_nxt = req_r.auto_pre ? SDCS_PRE_WAIT : SDCS_WR_WAIT;
			end
			SDCS_WR_WAIT: begin
				if (tdone && ras_done) begin // R7 R8 R11
					st_nxt = SDCS_PRE;
				end
			end
			SDCS_PRE: begin
				mem_nxt.cmd = CMD_PRECHARGE;
				mem_nxt.bank = req_r.bank;
				tload = 1'b1;
				tval = CNT_W'(PRECHARGE_CYC - 1);
				st_nxt = SDCS_PRE_WAIT;
			end
			SDCS_PRE_WAIT, SDCS_REF_WAIT: begin
				if (tdone) begin // R5
					st_nxt = SDCS_IDLE;
				end
			end
			SDCS_PDOWN: begin
				mem_nxt.cke = 1'b0;
				// Leaving power-down early to refresh keeps the contents safe.
				if (!pd_req || ref_due) begin // R10
					mem_nxt.cke = 1'b1;
					st_nxt = SDCS_IDLE;
				end
			end
			default: begin
				st_nxt = SDCS_POWERUP;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_r <= SDCS_POWERUP;
			mem_r <= '{cmd: CMD_INHIBIT, cke: 1'b1, bank: 2'h0, addr: 13'h0000};
			req_r <= '0;
			wake_r <= 2'h0;
			refage_r <= '0;
			init_r <= 1'b0;
			pu_r <= 32'h00000000;
		end else begin
			st_r <= st_nxt;
			mem_r <= mem_nxt;
			req_r <= req_nxt;
			wake_r <= wake_nxt;
			refage_r <= refage_nxt;
			init_r <= init_nxt;
			pu_r <= pu_nxt;
		end
	end

	assign mem = mem_r;
	assign init_done = init_r;
	assign wr_ready = (st_r == SDCS_IDLE) && !ref_due && !pd_req && (refage_r < CNT_W'(REFRESH_PERIOD_CYC));
	// Frequency may move only while the memory sits in power-down.
	assign clk_change_ok = clk_change_req && (st_r == SDCS_PDOWN) && (mem_r.cke == 1'b0); // R3

	logic [31:0] since_ref_r;
	logic [31:0] since_ref_nxt;

	// Spacing is measured from the command actually on the bus, not from the decision to send it.
	always_comb begin
		since_ref_nxt = since_ref_r + 32'h00000001;
		if (mem_r.cmd == CMD_REFRESH) begin
			since_ref_nxt = 32'h00000000;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			since_ref_r <= 32'h00000000;
		end else begin
			since_ref_r <= since_ref_nxt;
		end
	end

	refresh_idle_a: assert property (@(posedge mclk) disable iff (srst) // R5
		mem_r.cmd == CMD_REFRESH |=> (mem_r.cmd == CMD_NOP || mem_r.cmd == CMD_INHIBIT)[*3])
		else $error("command issued during refresh cycle interval");
	mode_idle_a: assert property (@(posedge mclk) disable iff (srst) // R6
		mem_r.cmd == CMD_MODE |=> mem_r.cmd == CMD_NOP)
		else $error("no idle command after mode load");
	wake_two_a: assert property (@(posedge mclk) disable iff (srst) // R1
		$rose(init_r) |-> $past(st_r) == SDCS_MODE_WAIT && pu_r >= 32'(POWERUP_CYCLES - 1))
		else $error("init done before power-up wake sequence");
	no_early_cmd_a: assert property (@(posedge mclk) disable iff (srst) // R1
		st_r == SDCS_POWERUP |-> mem_r.cmd == CMD_NOP || mem_r.cmd == CMD_INHIBIT)
		else $error("command during power-up pause");
	write_pre_a: assert property (@(posedge mclk) disable iff (srst) // R7
		mem_r.cmd == CMD_WRITE |=> (mem_r.cmd != CMD_PRECHARGE)[*2])
		else $error("precharge too soon after write");
	ras_min_a: assert property (@(posedge mclk) disable iff (srst) // R11
		mem_r.cmd == CMD_ACTIVE |=> (mem_r.cmd != CMD_PRECHARGE)[*2])
		else $error("precharge before row active minimum");
	refresh_age_a: assert property (@(posedge mclk) disable iff (srst) // R10
		init_r |-> since_ref_r <= 32'(REFRESH_PERIOD_CYC + 8))
		else $error("refresh period exceeded");
	clk_change_a: assert property (@(posedge mclk) disable iff (srst) // R3
		clk_change_ok |-> mem_r.cke == 1'b0 && mem_r.cmd == CMD_NOP && init_r)
		else $error("clock change allowed outside power-down");
	autopre_gap_a: assert property (@(posedge mclk) disable iff (srst) // R4
		mem_r.cmd == CMD_WRITE && mem_r.addr[AP_BIT] |=> (mem_r.cmd == CMD_NOP)[*3])
		else $error("command inside auto precharge recovery");
	// Power-down must never hide a command, and must give way to a due refresh.
	pdown_idle_a: assert property (@(posedge mclk) disable iff (srst) // R12
		mem_r.cke == 1'b0 |-> mem_r.cmd == CMD_NOP)
		else $error("command issued with clock enable low");
	pdown_exit_a: assert property (@(posedge mclk) disable iff (srst) // R10
		st_r == SDCS_PDOWN && ref_due |=> mem_r.cke == 1'b1)
		else $error("power-down kept although refresh due");
	ready_init_a: assert property (@(posedge mclk) disable iff (srst) // R1
		wr_ready |-> init_r)
		else $error("write accepted before initialisation");
endmodule // sdcs_ctrl

// File: tb/sdcs_mem_model.sv
`timescale 1ns/1ps
module sdcs_mem_model
	import sdcs_pkg::*;
#(
	parameter int PU = 20
)
(
	input  wire logic      mclk,
	input  wire logic      srst,
	input  wire sdcs_bus_t mem,
	output int             viol,
	output int             nref
);
	int   cyc, busy, age, t_act, t_wr, t_rdy;
	logic open_r;
	initial viol = 0;
	// Violations survive a reset so that a fault before a mid-run reset still counts.
	always @(posedge mclk) begin
		if (srst) begin
			cyc = 0;
			busy = 0;
			age = 0;
			nref = 0;
			t_rdy = 0;
			open_r = 1'b0;
		end else begin
			cyc++;
			age++;
			if (age > REFRESH_PERIOD_CYC)
				viol++;
			if (mem.cke && mem.cmd != CMD_NOP && mem.cmd != CMD_INHIBIT) begin
				if (busy > 0 || cyc < PU)
					viol++;
				case (mem.cmd)
					CMD_REFRESH: begin
						nref++;
						age = 0;
						busy = REFRESH_CYCLE_CYC;
					end
					CMD_MODE: begin
						if (nref < WAKE_REFRESHES)
							viol++;
						busy = MODE_LOAD_CYC;
					end
					CMD_ACTIVE: begin
						if (open_r || cyc < t_rdy)
							viol++;
						open_r = 1'b1;
						t_act = cyc;
					end
					CMD_WRITE: begin
						t_wr = cyc;
						if (!open_r)
							viol++;
						if (mem.addr[AP_BIT]) begin
							open_r = 1'b0;
							t_rdy = cyc + WRITE_RECOVERY_CYC + PRECHARGE_CYC;
						end
					end
					CMD_PRECHARGE: begin
						if (cyc - t_wr <= WRITE_RECOVERY_CYC || cyc - t_act < ROW_ACTIVE_CYC)
							viol++;
						open_r = 1'b0;
						t_rdy = cyc + PRECHARGE_CYC;
					end
					default: viol++;
				endcase
			end
			if (busy > 0)
				busy--;
		end
	end
endmodule // sdcs_mem_model

// File: tb/tb_sdcs_ctrl.sv
`timescale 1ns/1ps
module tb_sdcs_ctrl;
	import sdcs_pkg::*;
	localparam int PU = 20;
	logic        mclk, srst, wr_valid, wr_ready, pd_req, clk_change_req, clk_change_ok, init_done;
	sdcs_req_t   wr_req, cur;
	sdcs_bus_t   mem;
	int          n_fail = 0, checks = 0, viol, nref, cyc = 0, n_ref, n_mode, t_act, t_wr, t, k;
	logic [31:0] seed;
	sdcs_req_t   q[$];
	sdcs_ctrl #(.POWERUP_CYCLES(PU)) i_dut (.mclk(mclk), .srst(srst), .wr_valid(wr_valid), .wr_req(wr_req),
		.wr_ready(wr_ready), .pd_req(pd_req), .clk_change_req(clk_change_req), .clk_change_ok(clk_change_ok),
		.init_done(init_done), .mem(mem));
	sdcs_mem_model #(.PU(PU)) i_mem (.mclk(mclk), .srst(srst), .mem(mem), .viol(viol), .nref(nref));
	always #25 mclk = ~mclk;
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic reset_init();
		int n;
		n = 0;
		srst = 1'b1;
		repeat (4) @(negedge mclk);
		chk("rst_cmd", CMD_INHIBIT, mem.cmd);
		chk("rst_init", 0, init_done);
		srst = 1'b0;
		while (init_done !== 1'b1 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		chk("init_late", 1, n < 200);
		chk("init_early", 1, n > PU);
		chk("init_ref", WAKE_REFRESHES, n_ref);
		chk("init_mode", 1, n_mode);
	endtask
	task automatic do_write(sdcs_req_t r);
		int n;
		n = 0;
		wr_req = r;
		wr_valid = 1'b1;
		while (wr_ready !== 1'b1 && n < 400) begin
			@(negedge mclk);
			n++;
		end
		chk("wr_taken", 1, wr_ready);
		q.push_back(r);
		@(negedge mclk);
		wr_valid = 1'b0;
		@(negedge mclk);
	endtask
	// The bus is watched on the falling edge, where the registered commands have settled.
	always @(negedge mclk) begin
		cyc++;
		if (srst) begin
			n_ref = 0;
			n_mode = 0;
		end else if (mem.cke === 1'b1) begin
			if (mem.cmd === CMD_REFRESH)
				n_ref++;
			if (mem.cmd === CMD_MODE)
				n_mode++;
			if (mem.cmd === CMD_ACTIVE) begin
				chk("act_q", 1, q.size() > 0);
				if (q.size() > 0)
					cur = q.pop_front();
				t_act = cyc;
				chk("act_addr", {cur.bank, cur.row}, {mem.bank, mem.addr});
			end
			if (mem.cmd === CMD_WRITE) begin
				t_wr = cyc;
				chk("wr_addr", {cur.bank, cur.auto_pre, cur.col}, {mem.bank, mem.addr[AP_BIT], mem.addr[9:0]});
				chk("wr_gap", 3, cyc - t_act);
			end
			if (mem.cmd === CMD_PRECHARGE) begin
				chk("pre_manual", 0, cur.auto_pre);
				chk("pre_gap", 1, cyc - t_wr > WRITE_RECOVERY_CYC && cyc - t_act >= ROW_ACTIVE_CYC);
			end
		end
		if (clk_change_ok === 1'b1)
			chk("clk_ok_cke", 0, mem.cke);
	end
	initial begin
		mclk = 1'b0;
		srst = 1'b1;
		wr_valid = 1'b0;
		wr_req = '0;
		pd_req = 1'b0;
		clk_change_req = 1'b1;
		seed = 32'h190e6c01;
		reset_init();
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			do_write({seed[1:0], seed[14:2], seed[24:15], seed[25] ^ i[0]});
		end
		t = n_ref;
		repeat (400) @(negedge mclk);
		chk("idle_ref", 1, n_ref - t >= 400 / REFRESH_PERIOD_CYC);
		chk("model_ref", 1, n_ref - nref <= 1 && n_ref >= nref);
		pd_req = 1'b1;
		t = n_ref;
		k = 0;
		repeat (400) begin
			@(negedge mclk);
			if (mem.cke === 1'b0)
				k++;
			chk("clk_ok", clk_change_req && mem.cke === 1'b0, clk_change_ok);
			seed = lfsr(seed);
			clk_change_req = seed[3];
		end
		chk("pd_cke", 1, k > 200);
		chk("pd_ref", 1, n_ref - t >= 2);
		pd_req = 1'b0;
		repeat (20) @(negedge mclk);
		seed = lfsr(seed);
		do_write({seed[1:0], seed[14:2], seed[24:15], 1'b0});
		repeat (12) @(negedge mclk);
		reset_init();
		seed = lfsr(seed);
		do_write({seed[1:0], seed[14:2], seed[24:15], 1'b1});
		repeat (30) @(negedge mclk);
		chk("q_left", 0, q.size());
		chk("viol", 0, viol);
		final_report();
	end
	initial begin
		#(50 * 20000);
		n_fail++;
		final_report();
	end
endmodule // tb_sdcs_ctrl
